// ==== core/sfag_regs.vh ====
// Register map, field positions, reset values and codes of the flash access guard
`ifndef SFAG_REGS_VH
`define SFAG_REGS_VH

// --------------------
// Register byte offsets
// --------------------
`define SFAG_OFF_CTRL_STATUS 8'h24
`define SFAG_OFF_ADDR 8'h28
`define SFAG_OFF_DATA 8'h2C
`define SFAG_OFF_KEY 8'h30
`define SFAG_OFF_STATUS 8'h34
`define SFAG_OFF_OPTION 8'h38

// --------------------
// Control/status fields and reset values
// --------------------
`define SFAG_CS_START 0
`define SFAG_CS_OP_LO 1
`define SFAG_CS_OP_HI 3
`define SFAG_CS_SEC_LO 4
`define SFAG_CS_SEC_HI 5
`define SFAG_CS_REFUSED 6
`define SFAG_CS_BUSY 7
`define SFAG_CS_RESET 8'h00
`define SFAG_OPT_RESET 8'h00
`define SFAG_OPT_PROTECT 0

// --------------------
// Operation codes, also driven to the flash array
// --------------------
`define SFAG_OP_NONE 3'h0
`define SFAG_OP_PROGRAM 3'h1
`define SFAG_OP_SECTOR_ERASE 3'h2
`define SFAG_OP_MASS_ERASE 3'h3
`define SFAG_OP_OPTION 3'h4

// --------------------
// Write guard keys and link entry code (values are arbitrary)
// --------------------
`define SFAG_KEY_FIRST 8'h5A
`define SFAG_KEY_SECOND 8'hC3
`define SFAG_LINK_ENTRY 8'h3C
`define SFAG_AXI_OKAY 2'h0
`define SFAG_AXI_SLVERR 2'h2

`endif

// ==== core/sfag_sync3.v ====
// Three-stage input synchroniser with agreement filter
`default_nettype none

module sfag_sync3 #(
    parameter W = 1
) (
    input wire core_clk_i,
    input wire reset_n_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] level_o
);

    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    reg [W-1:0] level_reg;
    integer k;

    // First stage feeds only the second; the filter compares stages two and three
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
            level_reg <= {W{1'b0}};
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (k = 0; k < W; k = k + 1) begin
                if (s2_reg[k] == s3_reg[k]) begin
                    level_reg[k] <= s2_reg[k];
                end
            end
        end
    end

    assign level_o = level_reg;

endmodule // sfag_sync3

`default_nettype wire

// ==== core/sfag_top.v ====
// Flash access guard: AXI4-Lite registers, protection checks and operation sequencer
//
// Local design decision: the AXI4-Lite slave port.
`include "sfag_regs.vh"
`default_nettype none

// How it works
// - Software may request a whole-array erase, a single-sector erase, or a one-byte program.
// - Each sector erase names one sector to the array, so the other sectors are not touched; a whole-array erase wipes every sector.
// - Only sector 0 exists for a 4K array, sectors 0 and 1 for 8K, and sectors 0 to 2 above that.
// - Sector 0 is F000h-FFFFh, sector 1 the 4 Kbytes below it, and sector 0 holds the vectors.
// - While read-out protection is on, link read-out is blocked and every program, sector erase and whole-array erase request is refused.
// - A single option-byte bit switches protection, and only an option program removes it.
// - Removing protection first erases the whole array, then writes the new option byte.
// - With a tool insertion or an in-circuit session, all sectors and the option byte are writable.
// - In in-application mode sector 0, whole-array erase and option writes are refused.
// - The serial clock and data pins belong to the link whenever the tool is attached.
// - An eight-bit control/status register at 0024h, reset 00h, starts and reports operations.
// - A start is only taken right after the two guard keys were written in order.
module sfag_top #(
    parameter FLASH_KB = 16
) (
    input wire core_clk_i,
    input wire reset_n_i,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Pins and straps
    input wire tool_insert_i,
    input wire tool_attached_i,
    input wire link_serial_clock_pin_i,
    input wire link_serial_data_pin_i,
    output wire link_serial_data_pin_o,
    output wire link_serial_data_pin_oe_o,
    output wire link_pins_owned_o,
    output wire link_readout_en_o,
    input wire [7:0] option_byte_i,
    // Flash array command port
    output wire flash_req_o,
    output wire [2:0] flash_cmd_o,
    output wire [1:0] flash_sector_o,
    output wire [15:0] flash_addr_o,
    output wire [7:0] flash_wdata_o,
    input wire flash_done_i
);

    // --------------------
    // Array geometry
    // --------------------
    localparam integer NUM_SECT = (FLASH_KB <= 4) ? 1 : ((FLASH_KB <= 8) ? 2 : 3);
    localparam integer ARRAY_BASE_I = 65536 - FLASH_KB * 1024;
    localparam [16:0] ARRAY_BASE = ARRAY_BASE_I[16:0];
    localparam [1:0] SECT_LIMIT = NUM_SECT[1:0];

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RUN = 4'h2;
    localparam [3:0] ST_UNP_ERASE = 4'h4;
    localparam [3:0] ST_UNP_OPT = 4'h8;

    // Sector of a byte address: 4K blocks from the top down, the rest is sector 2
    function [1:0] sector_of;
        input [15:0] a;
        begin
            if (a[15:12] == 4'hF) begin
                sector_of = 2'h0;
            end else if (a[15:12] == 4'hE) begin
                sector_of = 2'h1;
            end else begin
                sector_of = 2'h2;
            end
        end
    endfunction

    // Whether a sector may be written in the present mode
    function sector_ok;
        input [1:0] s;
        input full;
        begin
            sector_ok = (s < SECT_LIMIT) && (full || (s != 2'h0));
        end
    endfunction

    // --------------------
    // Pin synchronisers
    // --------------------
    wire [3:0] pins_f;
    wire insert_f = pins_f[0];
    wire attached_f = pins_f[1];
    wire lclk_f = pins_f[2];
    wire ldata_f = pins_f[3];

    sfag_sync3 #(.W(4)) u_sync (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({link_serial_data_pin_i, link_serial_clock_pin_i, tool_attached_i, tool_insert_i}),
        .level_o(pins_f)
    );

    // --------------------
    // Link receiver and session entry
    // --------------------
    reg lclk_prev_reg;
    reg [7:0] lshift_reg;
    reg [2:0] lcount_reg;
    reg [7:0] lrx_reg;
    reg session_reg;
    reg owned_reg;
    reg readout_reg;
    reg [7:0] opt_reg;
    wire full_mode = insert_f | session_reg;

    // Bits are taken on link clock rising edges; the session ends when the tool leaves
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            lclk_prev_reg <= 1'b0;
            lshift_reg <= 8'h00;
            lcount_reg <= 3'h0;
            lrx_reg <= 8'h00;
            session_reg <= 1'b0;
            owned_reg <= 1'b0;
            readout_reg <= 1'b0;
        end else begin
            lclk_prev_reg <= lclk_f;
            owned_reg <= attached_f;
            readout_reg <= attached_f & session_reg & ~opt_reg[`SFAG_OPT_PROTECT];
            if (!attached_f) begin
                lcount_reg <= 3'h0;
                session_reg <= 1'b0;
            end else if (lclk_f && !lclk_prev_reg) begin
                lshift_reg <= {lshift_reg[6:0], ldata_f};
                lcount_reg <= lcount_reg + 3'h1;
                if (lcount_reg == 3'h7) begin
                    lrx_reg <= {lshift_reg[6:0], ldata_f};
                    // Entry code sent by the tool opens the in-circuit session
                    if ({lshift_reg[6:0], ldata_f} == `SFAG_LINK_ENTRY) begin
                        session_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // --------------------
    // AXI4-Lite handshakes
    // --------------------
    reg awready_reg;
    reg wready_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg arready_reg;
    reg rvalid_reg;
    reg [1:0] rresp_reg;
    reg [31:0] rdata_reg;
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire wr_map = (aw_addr_reg == `SFAG_OFF_CTRL_STATUS) || (aw_addr_reg == `SFAG_OFF_ADDR) ||
                  (aw_addr_reg == `SFAG_OFF_DATA) || (aw_addr_reg == `SFAG_OFF_KEY);
    wire wr_b0 = wr_go & wr_map & w_strb_reg[0];

    // Address and data are latched independently, so either may arrive first
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SFAG_AXI_OKAY;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && awready_reg) begin
                aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'b00};
                aw_hold_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_reg) begin
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
                w_hold_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_map ? `SFAG_AXI_OKAY : `SFAG_AXI_SLVERR;
            end
            if (bvalid_reg && s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // --------------------
    // Register file and operation sequencer
    // --------------------
    reg [7:0] cs_reg;
    reg [15:0] addr_reg;
    reg [7:0] data_reg;
    reg [1:0] key_stage_reg;
    reg opt_loaded_reg;
    reg [3:0] state_reg;
    reg req_reg;
    reg [2:0] cmd_reg;
    reg [1:0] fsec_reg;
    reg [15:0] faddr_reg;
    reg [7:0] fdata_reg;

    wire [7:0] wb = w_data_reg[7:0];
    wire cs_wr = wr_b0 && (aw_addr_reg == `SFAG_OFF_CTRL_STATUS);
    wire key_wr = wr_b0 && (aw_addr_reg == `SFAG_OFF_KEY);
    wire start_req = cs_wr && wb[`SFAG_CS_START];
    wire [2:0] op_w = wb[`SFAG_CS_OP_HI:`SFAG_CS_OP_LO];
    wire [1:0] sec_w = wb[`SFAG_CS_SEC_HI:`SFAG_CS_SEC_LO];
    wire prot = opt_reg[`SFAG_OPT_PROTECT];
    wire unprotect = prot && !data_reg[`SFAG_OPT_PROTECT];
    reg allowed;

    // Decide whether the requested operation passes mode, sector and protection checks
    always @* begin
        allowed = 1'b0;
        case (op_w)
            `SFAG_OP_PROGRAM: allowed = !prot && ({1'b0, addr_reg} >= ARRAY_BASE) &&
                                        sector_ok(sector_of(addr_reg), full_mode);
            `SFAG_OP_SECTOR_ERASE: allowed = !prot && sector_ok(sec_w, full_mode);
            `SFAG_OP_MASS_ERASE: allowed = !prot && full_mode;
            `SFAG_OP_OPTION: allowed = full_mode;
            default: allowed = 1'b0;
        endcase
    end

    wire idle = (state_reg == ST_IDLE);
    wire take = start_req && idle && (key_stage_reg == 2'h2) && allowed;
    wire refuse = start_req && !take;

    // Control path: guard keys, stored fields, sticky refusal and the sequencer itself
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cs_reg <= `SFAG_CS_RESET;
            addr_reg <= 16'h0000;
            data_reg <= 8'h00;
            key_stage_reg <= 2'h0;
            opt_reg <= `SFAG_OPT_RESET;
            opt_loaded_reg <= 1'b0;
            state_reg <= ST_IDLE;
            req_reg <= 1'b0;
            cmd_reg <= `SFAG_OP_NONE;
            fsec_reg <= 2'h0;
            faddr_reg <= 16'h0000;
            fdata_reg <= 8'h00;
        end else begin
            // Option byte is caught once after reset release, like a strap
            if (!opt_loaded_reg) begin
                opt_reg <= option_byte_i;
                opt_loaded_reg <= 1'b1;
            end
            if (wr_b0 && (aw_addr_reg == `SFAG_OFF_ADDR)) begin
                addr_reg[7:0] <= wb;
            end
            if (wr_go && wr_map && w_strb_reg[1] && (aw_addr_reg == `SFAG_OFF_ADDR)) begin
                addr_reg[15:8] <= w_data_reg[15:8];
            end
            if (wr_b0 && (aw_addr_reg == `SFAG_OFF_DATA)) begin
                data_reg <= wb;
            end
            // Any mapped write with byte 0 enabled, other than a valid key step, drops the guard back to locked
            if (key_wr && (wb == `SFAG_KEY_FIRST)) begin
                key_stage_reg <= 2'h1;
            end else if (key_wr && (wb == `SFAG_KEY_SECOND) && (key_stage_reg == 2'h1)) begin
                key_stage_reg <= 2'h2;
            end else if (wr_b0) begin
                key_stage_reg <= 2'h0;
            end
            if (cs_wr) begin
                cs_reg[`SFAG_CS_SEC_HI:`SFAG_CS_OP_LO] <= wb[`SFAG_CS_SEC_HI:`SFAG_CS_OP_LO];
                if (wb[`SFAG_CS_REFUSED]) begin
                    cs_reg[`SFAG_CS_REFUSED] <= 1'b0;
                end
            end
            // A refusal in the same cycle as its clear stays set
            if (refuse) begin
                cs_reg[`SFAG_CS_REFUSED] <= 1'b1;
            end
            cs_reg[`SFAG_CS_BUSY] <= !idle || take;
            case (state_reg)
                ST_IDLE: begin
                    if (take) begin
                        req_reg <= 1'b1;
                        faddr_reg <= addr_reg;
                        fdata_reg <= data_reg;
                        fsec_reg <= (op_w == `SFAG_OP_PROGRAM) ? sector_of(addr_reg) : sec_w;
                        if ((op_w == `SFAG_OP_OPTION) && unprotect) begin
                            cmd_reg <= `SFAG_OP_MASS_ERASE;
                            state_reg <= ST_UNP_ERASE;
                        end else begin
                            cmd_reg <= op_w;
                            state_reg <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (flash_done_i) begin
                        req_reg <= 1'b0;
                        cmd_reg <= `SFAG_OP_NONE;
                        state_reg <= ST_IDLE;
                        if (cmd_reg == `SFAG_OP_OPTION) begin
                            opt_reg <= fdata_reg;
                        end
                    end
                end
                ST_UNP_ERASE: begin
                    // Protection stays on until the whole array has been wiped
                    if (flash_done_i) begin
                        cmd_reg <= `SFAG_OP_OPTION;
                        state_reg <= ST_UNP_OPT;
                    end
                end
                ST_UNP_OPT: begin
                    if (flash_done_i) begin
                        req_reg <= 1'b0;
                        cmd_reg <= `SFAG_OP_NONE;
                        opt_reg <= fdata_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    req_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
            if (take) begin
                key_stage_reg <= 2'h0;
            end
        end
    end

    // --------------------
    // Read path
    // --------------------
    reg [31:0] rd_val;
    reg rd_hit;

    // Status word: guard stage, mode, protection and last link byte
    always @* begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr_i[7:2], 2'b00})
            `SFAG_OFF_CTRL_STATUS: rd_val = {24'h000000, cs_reg};
            `SFAG_OFF_ADDR: rd_val = {16'h0000, addr_reg};
            `SFAG_OFF_DATA: rd_val = {24'h000000, data_reg};
            `SFAG_OFF_KEY: rd_val = 32'h0000_0000;
            `SFAG_OFF_STATUS: rd_val = {16'h0000, lrx_reg, 1'b0, session_reg, insert_f, attached_f,
                                        prot, full_mode, key_stage_reg};
            `SFAG_OFF_OPTION: rd_val = {24'h000000, opt_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read answered one cycle after the address is taken
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= `SFAG_AXI_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (s_axi_arvalid_i && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_val;
                rresp_reg <= rd_hit ? `SFAG_AXI_OKAY : `SFAG_AXI_SLVERR;
            end
            if (rvalid_reg && s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // --------------------
    // Outputs, all from flops; the data pin is only listened to
    // --------------------
    reg ldata_out_reg;
    reg ldata_oe_reg;
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ldata_out_reg <= 1'b0;
            ldata_oe_reg <= 1'b0;
        end else begin
            ldata_out_reg <= 1'b0;
            ldata_oe_reg <= 1'b0;
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign link_serial_data_pin_o = ldata_out_reg;
    assign link_serial_data_pin_oe_o = ldata_oe_reg;
    assign link_pins_owned_o = owned_reg;
    assign link_readout_en_o = readout_reg;
    assign flash_req_o = req_reg;
    assign flash_cmd_o = cmd_reg;
    assign flash_sector_o = fsec_reg;
    assign flash_addr_o = faddr_reg;
    assign flash_wdata_o = fdata_reg;

endmodule // sfag_top

`default_nettype wire

// ==== dv/sfag_tool_model.sv ====
// Programming tool model: link clock and serial data into the guard
`default_nettype none
module sfag_tool_model (
    output logic clk_o,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        clk_o = 1'b0;
        data_o = 1'b1;
    end
    // Clock runs only inside a frame; bit set while low, MSB first
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            data_o = b[i];
            #400 clk_o = 1'b1;
            #400 clk_o = 1'b0;
        end
        data_o = ~data_o; // No pull on the line, so show the inverse
    endtask
endmodule // sfag_tool_model
`default_nettype wire

// ==== dv/sfag_top_properties.sv ====
// Port-level assertions for the flash access guard
`default_nettype none
module sfag_top_properties #(
    parameter FLASH_KB = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic tool_insert_i,
    input wire logic tool_attached_i,
    input wire logic link_serial_data_pin_oe_o,
    input wire logic flash_req_o,
    input wire logic [2:0] flash_cmd_o,
    input wire logic [1:0] flash_sector_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic flash_done_i
);
    localparam int NSEC = (FLASH_KB <= 4) ? 1 : (FLASH_KB <= 8) ? 2 : 3;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Bus answers and channel locking
    chk_b_answer:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##[1:2] s_axi_bvalid_o) else $error("write response missing");
    chk_ready_low:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
    chk_r_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read data missing");
    // Array command port
    chk_req_stable:
    assert property (flash_req_o && !flash_done_i |=> flash_req_o && $stable(flash_cmd_o) && $stable(flash_addr_o))
        else $error("array step not held");
    chk_cmd_legal:
    assert property (flash_req_o |-> flash_cmd_o inside {3'h1, 3'h2, 3'h3, 3'h4}) else $error("bad array command");
    chk_sector_count:
    assert property (flash_req_o && flash_cmd_o == 3'h2 |-> flash_sector_o < NSEC) else $error("absent sector");
    // Without a tool only sectors other than 0 may change
    chk_iap_guard:
    assert property ($rose(flash_req_o) && !tool_insert_i && !tool_attached_i
        |-> (flash_cmd_o == 3'h1 && flash_addr_o < 16'hF000) || (flash_cmd_o == 3'h2 && flash_sector_o != 2'h0))
        else $error("sector 0 touched in application mode");
    chk_pin_released:
    assert property (!link_serial_data_pin_oe_o) else $error("data pin driven");
    cov_erase: cover property ($rose(flash_req_o) && flash_cmd_o == 3'h2);
    cov_mass: cover property ($rose(flash_req_o) && flash_cmd_o == 3'h3);
    cov_option: cover property (flash_req_o && flash_cmd_o == 3'h4);
endmodule // sfag_top_properties
bind sfag_top sfag_top_properties #(.FLASH_KB(FLASH_KB)) u_props (.core_clk_i, .reset_n_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rvalid_o, .tool_insert_i, .tool_attached_i, .link_serial_data_pin_oe_o, .flash_req_o, .flash_cmd_o,
    .flash_sector_o, .flash_addr_o, .flash_done_i);
`default_nettype wire

// ==== dv/tb_sfag_top.sv ====
// Self-checking bench for the flash access guard
`default_nettype none
module tb_sfag_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i, reset_n_i, awv, wv, bry, arv, rry, ins, att, done, req_q;
    logic [7:0] awa, ara, opt;
    logic [31:0] wd, got;
    logic [1:0] resp, sec_seen;
    logic [2:0] cmd_seen;
    logic [15:0] addr_seen;
    wire awr, wro, bv, arr, rv, dpo, doe, own, roe, req, lclk, ldat;
    wire [1:0] br, rr, sec;
    wire [31:0] rdo;
    wire [2:0] cmd;
    wire [15:0] fa;
    wire [7:0] fw;
    int failures, check_count, cyc, starts;
    sfag_tool_model tool (.clk_o(lclk), .data_o(ldat));
    sfag_top #(.FLASH_KB(16)) DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wro), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rry), .tool_insert_i(ins), .tool_attached_i(att), .link_serial_clock_pin_i(lclk),
        .link_serial_data_pin_i(ldat), .link_serial_data_pin_o(dpo), .link_serial_data_pin_oe_o(doe),
        .link_pins_owned_o(own), .link_readout_en_o(roe), .option_byte_i(opt), .flash_req_o(req),
        .flash_cmd_o(cmd), .flash_sector_o(sec), .flash_addr_o(fa), .flash_wdata_o(fw), .flash_done_i(done));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // Array answers one cycle into each step; the first step of each request is recorded; hangs are cut off
    always @(posedge core_clk_i) begin
        done <= req && !done;
        req_q <= req;
        if (req && !req_q) begin
            starts++;
            cmd_seen <= cmd;
            sec_seen <= sec;
            addr_seen <= fa;
        end
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    // Bus master: each channel held until its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (awr)
                awv <= 1'b0;
            if (wro)
                wv <= 1'b0;
        end while (!bv);
        resp = br;
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (arr)
                arv <= 1'b0;
        end while (!rv);
        got = rdo;
        resp = rr;
        rry <= 1'b0;
    endtask
    // The bench owns reset; only this task pulses it, low for four cycles, then six to settle
    task automatic rst;
        reset_n_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
    endtask
    // Load, unlock and start one step; judge the array port and the refused flag
    task automatic op(input logic [2:0] c, input logic [1:0] s, input logic [15:0] a, input logic ok);
        int n;
        n = starts;
        wr(8'h28, {16'h0, a});
        wr(8'h2C, 32'h0);
        wr(8'h30, 32'h5A);
        wr(8'h30, 32'hC3);
        wr(8'h24, {26'h0, s, c, 1'b1});
        repeat (12) @(posedge core_clk_i);
        cmp(32'(starts - n), {31'h0, ok});
        if (ok)
            cmp(32'(cmd_seen), 32'(c == 3'h4 && opt[0] ? 3'h3 : c));
        if (ok && c == 3'h2)
            cmp(32'(sec_seen), 32'(s));
        if (ok && c == 3'h1)
            cmp(32'(addr_seen), 32'(a));
        rd(8'h24);
        cmp(32'(got[6]), 32'(!ok));
        wr(8'h24, 32'h40);
    endtask
    task automatic t_regs;
        rd(8'h24);
        cmp(got, 32'h0);
        rd(8'h3C);
        cmp(32'(resp), 32'h2);
        wr(8'h24, 32'h15);
        rd(8'h24);
        cmp(32'(got[7:6]), 32'h1);
        wr(8'h24, 32'h40);
    endtask
    task automatic t_iap;
        for (int s = 0; s < 3; s++)
            op(3'h2, 2'(s), 16'h0, s != 0);
        op(3'h1, 2'h0, 16'hF010, 1'b0);
        op(3'h1, 2'h1, 16'hE123, 1'b1);
        op(3'h3, 2'h0, 16'h0, 1'b0);
    endtask
    task automatic t_full;
        ins <= 1'b1;
        op(3'h3, 2'h0, 16'h0, 1'b1);
        op(3'h2, 2'h0, 16'h0, 1'b1);
        ins <= 1'b0;
    endtask
    task automatic t_prot;
        opt <= 8'h01;
        rst();
        op(3'h1, 2'h1, 16'hE123, 1'b0);
        ins <= 1'b1;
        op(3'h4, 2'h0, 16'h0, 1'b1);
        rd(8'h38);
        cmp(got, 32'h0);
        op(3'h1, 2'h1, 16'hE123, 1'b1);
        ins <= 1'b0;
        opt <= 8'h00;
    endtask
    task automatic t_link;
        att <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        #37 tool.send(8'h3C);
        repeat (8) @(posedge core_clk_i);
        cmp(32'(own), 32'h1);
        cmp(32'(roe), 32'h1);
        cmp(32'({dpo, doe}), 32'h0);
        rd(8'h34);
        cmp(32'(got[15:8]), 32'h3C);
        op(3'h2, 2'h0, 16'h0, 1'b1);
        att <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        cmp(32'({own, roe}), 32'h0);
    endtask
    initial begin
        {reset_n_i, awv, wv, bry, arv, rry, ins, att, done, req_q} = '0;
        {awa, ara, opt, wd} = '0;
        rst();
        t_regs();
        t_iap();
        t_full();
        t_prot();
        t_link();
        test_done();
    end
endmodule // tb_sfag_top
`default_nettype wire
